// [cipc_pkg.sv]
// Constants, types and register map of the core interrupt unit
package cipc_pkg;

  // ****************************************************
  // Sizes
  // ****************************************************
  localparam int NVEC = 32;
  localparam int VW = 5;

  // ****************************************************
  // Register indices (byte address is four times index)
  // ****************************************************
  localparam logic [2:0] IDX_CTRL = 3'h0;
  localparam logic [2:0] IDX_STAT = 3'h1;
  localparam logic [2:0] IDX_PRI = 3'h2;
  localparam logic [2:0] IDX_HVEC = 3'h3;
  localparam logic [2:0] IDX_UNLK = 3'h4;

  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int CTRL_RR = 0;
  localparam int CTRL_CVT = 5;
  localparam int CTRL_VECTOR_PLACEMENT_SELECT = 6;
  localparam int STAT_L0 = 0;
  localparam int STAT_L1 = 1;
  localparam int STAT_NMI = 7;

  // ****************************************************
  // Reset values and keys
  // ****************************************************
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] PRI_RST = 8'h00;
  localparam logic [7:0] HVEC_RST = 8'h00;
  localparam logic [7:0] HVEC_NONE = 8'h00;
  localparam logic [7:0] UNLOCK_KEY = 8'h5a;
  localparam logic [2:0] UNLOCK_INSTR = 3'h4;

  // ****************************************************
  // Vector map
  // ****************************************************
  localparam logic [NVEC-1:0] NMI_MASK = 32'h0000_0002;
  localparam logic [NVEC-1:0] RESET_MASK = 32'h0000_0001;
  localparam logic [VW-1:0] FIXED_PTR = 5'h1f;
  localparam logic [7:0] CVT_VEC_NMI = 8'h01;
  localparam logic [7:0] CVT_VEC_L1 = 8'h02;
  localparam logic [7:0] CVT_VEC_L0 = 8'h03;

  // ****************************************************
  // Types
  // ****************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_OFFER = 2'b01,
    ST_SETTLE = 2'b11
  } cipc_state_e;

  typedef enum logic [1:0] {
    LVL_0 = 2'b00,
    LVL_1 = 2'b01,
    LVL_NMI = 2'b10
  } cipc_level_e;

  typedef struct packed {
    logic req;
    cipc_level_e lvl;
    logic [7:0] vec;
  } cipc_offer_s;

endpackage

// [cipc_rot_arb.sv]
// Rotating-pointer arbiter: search starts one past the pointer
`timescale 1ns/1ps
module cipc_rot_arb import cipc_pkg::*; (
  // Requests, one per vector number
  input wire logic [NVEC-1:0] req,
  input wire logic [VW-1:0] ptr,
  // Result
  output logic found,
  output logic [VW-1:0] win
);

  logic [VW-1:0] idx [NVEC];
  logic [NVEC-1:0] hit;

  // Slot k looks at vector ptr+1+k, wrapping at the table size
  for (genvar k = 0; k < NVEC; k++) begin : g_slot
    assign idx[k] = ptr + VW'(k + 1);
    assign hit[k] = req[idx[k]];
  end

  // First hit in slot order wins; scan from the back so it overrides
  always_comb begin
    found = 1'b0;
    win = '0;
    for (int i = NVEC - 1; i >= 0; i--) begin
      if (hit[i]) begin
        found = 1'b1;
        win = idx[i];
      end
    end
  end

endmodule // cipc_rot_arb

// [cipc_core_interrupt_unit.sv]
// Core interrupt unit: APB registers, level arbitration, core handshake
`timescale 1ns/1ps
module cipc_core_interrupt_unit import cipc_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Peripheral request lines, indexed by vector number
  input wire logic [NVEC-1:0] irq_lines,
  // Processor core side
  input wire logic gie,
  input wire logic instr_done,
  input wire logic int_ack,
  input wire logic return_from_interrupt,
  input wire logic boot_all,
  output cipc_offer_s offer,
  output logic vec_boot_start
);

  // ****************************************************
  // State
  // ****************************************************
  logic rr_q, rr_d, cvt_q, cvt_d, vector_placement_select_q, vector_placement_select_d;
  logic [7:0] pri_q, pri_d, hvec_q, hvec_d;
  logic [2:0] unlk_q, unlk_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic place_q, place_d;
  logic nmi_ex_q, nmi_ex_d, l1_ex_q, l1_ex_d, l0_ex_q, l0_ex_d;
  cipc_state_e state_q, state_d;
  cipc_offer_s offer_q, offer_d;
  logic [7:0] win_q, win_d;

  // ****************************************************
  // Bus decode
  // ****************************************************
  logic setup, wr, mapped, rr_load, take;
  logic [2:0] idx;
  logic [31:0] rd_mux;

  assign idx = paddr[4:2];
  assign mapped = (paddr[7:5] == 3'h0) && (idx <= IDX_UNLK);
  assign setup = psel && !penable;
  // Writes commit only on the edge where the access phase sees pready
  assign wr = psel && penable && pready_q && pwrite && mapped;
  // Acknowledge is only meaningful while an offer stands
  assign take = (state_q == ST_OFFER) && int_ack;
  assign rr_load = take && (offer_q.lvl == LVL_0) && rr_q;

  // Read data selection, reserved bits read as zero
  always_comb begin
    rd_mux = '0;
    case (idx)
      IDX_CTRL: begin
        rd_mux[CTRL_RR] = rr_q;
        rd_mux[CTRL_CVT] = cvt_q;
        rd_mux[CTRL_VECTOR_PLACEMENT_SELECT] = vector_placement_select_q;
      end
      IDX_STAT: begin
        rd_mux[STAT_NMI] = nmi_ex_q;
        rd_mux[STAT_L1] = l1_ex_q;
        rd_mux[STAT_L0] = l0_ex_q;
      end
      IDX_PRI: rd_mux[7:0] = pri_q;
      IDX_HVEC: rd_mux[7:0] = hvec_q;
      IDX_UNLK: rd_mux[0] = (unlk_q != 3'h0);
      default: rd_mux = '0;
    endcase
  end

  // ****************************************************
  // Register file and bus answer
  // ****************************************************
  // Answer is prepared in setup so every output is a flop
  always_comb begin
    pready_d = setup;
    pslverr_d = setup && !mapped;
    prdata_d = (setup && !pwrite && mapped) ? rd_mux : 32'h0000_0000;
    rr_d = rr_q;
    cvt_d = cvt_q;
    vector_placement_select_d = vector_placement_select_q;
    pri_d = pri_q;
    hvec_d = hvec_q;
    unlk_d = unlk_q;
    // Window counts down on retired instructions of the core
    if (unlk_q != 3'h0 && instr_done) begin
      unlk_d = unlk_q - 3'h1;
    end
    if (wr && idx == IDX_UNLK) begin
      unlk_d = (pwdata[7:0] == UNLOCK_KEY) ? UNLOCK_INSTR : 3'h0;
    end
    if (wr && idx == IDX_CTRL) begin
      rr_d = pwdata[CTRL_RR];
      if (unlk_q != 3'h0) begin
        cvt_d = pwdata[CTRL_CVT];
        vector_placement_select_d = pwdata[CTRL_VECTOR_PLACEMENT_SELECT];
      end
    end
    if (wr && idx == IDX_HVEC) begin
      hvec_d = pwdata[7:0];
    end
    // Hardware load wins over a software write in the same cycle
    if (rr_load) begin
      pri_d = win_q;
    end else if (wr && idx == IDX_PRI) begin
      pri_d = pwdata[7:0];
    end
    place_d = vector_placement_select_q && !boot_all;
  end

  // Register the configuration and bus answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rr_q <= CTRL_RST[CTRL_RR];
      cvt_q <= CTRL_RST[CTRL_CVT];
      vector_placement_select_q <= CTRL_RST[CTRL_VECTOR_PLACEMENT_SELECT];
      pri_q <= PRI_RST;
      hvec_q <= HVEC_RST;
      unlk_q <= 3'h0;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      place_q <= 1'b0;
    end else begin
      rr_q <= rr_d;
      cvt_q <= cvt_d;
      vector_placement_select_q <= vector_placement_select_d;
      pri_q <= pri_d;
      hvec_q <= hvec_d;
      unlk_q <= unlk_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      place_q <= place_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign vec_boot_start = place_q;
  assign offer = offer_q;

  // ****************************************************
  // Request classification
  // ****************************************************
  logic hvec_ok, hi_hit, nmi_found, l0_found;
  logic can_nmi, can_l1, can_l0;
  logic [NVEC-1:0] hsel_mask, nmi_req, l0_req;
  logic [VW-1:0] nmi_win, l0_win;

  // Out-of-range high vectors are treated as no promotion at all
  assign hvec_ok = (hvec_q != HVEC_NONE) && (hvec_q[7:VW] == '0);
  assign hsel_mask = hvec_ok ? (NVEC'(1) << hvec_q[VW-1:0]) : '0;
  assign hi_hit = |(irq_lines & hsel_mask & ~NMI_MASK);
  assign nmi_req = irq_lines & NMI_MASK;
  assign l0_req = irq_lines & ~NMI_MASK & ~RESET_MASK & ~hsel_mask;
  // Non-maskable ignores global enable; level 1 ignores level 0 running
  assign can_nmi = !nmi_ex_q;
  assign can_l1 = gie && !nmi_ex_q && !l1_ex_q;
  assign can_l0 = gie && !nmi_ex_q && !l1_ex_q && !l0_ex_q;

  // Non-maskable sources are fixed: the lowest number always wins
  cipc_rot_arb u_nmi_arb (
    .req(nmi_req),
    .ptr(FIXED_PTR),
    .found(nmi_found),
    .win(nmi_win)
  );

  // Both normal modes rotate from the pointer; only its update differs
  cipc_rot_arb u_l0_arb (
    .req(l0_req),
    .ptr(pri_q[VW-1:0]),
    .found(l0_found),
    .win(l0_win)
  );

  // ****************************************************
  // Offer sequencing and execution status
  // ****************************************************
  always_comb begin
    state_d = state_q;
    offer_d = offer_q;
    win_d = win_q;
    nmi_ex_d = nmi_ex_q;
    l1_ex_d = l1_ex_q;
    l0_ex_d = l0_ex_q;
    // Return clears only the innermost running level
    if (return_from_interrupt) begin
      if (nmi_ex_q) begin
        nmi_ex_d = 1'b0;
      end else if (l1_ex_q) begin
        l1_ex_d = 1'b0;
      end else begin
        l0_ex_d = 1'b0;
      end
    end
    case (state_q)
      ST_IDLE, ST_OFFER: begin
        if (take) begin
          case (offer_q.lvl)
            LVL_NMI: nmi_ex_d = 1'b1;
            LVL_1: l1_ex_d = 1'b1;
            default: l0_ex_d = 1'b1;
          endcase
          offer_d.req = 1'b0;
          state_d = ST_SETTLE;
        end else if (nmi_found && can_nmi) begin
          offer_d.req = 1'b1;
          offer_d.lvl = LVL_NMI;
          win_d = {{(8 - VW){1'b0}}, nmi_win};
          offer_d.vec = cvt_q ? CVT_VEC_NMI : win_d;
          state_d = ST_OFFER;
        end else if (hi_hit && can_l1) begin
          offer_d.req = 1'b1;
          offer_d.lvl = LVL_1;
          win_d = hvec_q;
          offer_d.vec = cvt_q ? CVT_VEC_L1 : hvec_q;
          state_d = ST_OFFER;
        end else if (l0_found && can_l0) begin
          offer_d.req = 1'b1;
          offer_d.lvl = LVL_0;
          win_d = {{(8 - VW){1'b0}}, l0_win};
          offer_d.vec = cvt_q ? CVT_VEC_L0 : win_d;
          state_d = ST_OFFER;
        end else begin
          offer_d.req = 1'b0;
          state_d = ST_IDLE;
        end
      end
      // One quiet cycle lets the new status gate the next choice
      ST_SETTLE: state_d = ST_IDLE;
      default: begin
        state_d = ST_IDLE;
        offer_d = '0;
      end
    endcase
  end

  // Status bits change only through entry and return
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      offer_q <= '0;
      win_q <= 8'h00;
      nmi_ex_q <= 1'b0;
      l1_ex_q <= 1'b0;
      l0_ex_q <= 1'b0;
    end else begin
      state_q <= state_d;
      offer_q <= offer_d;
      win_q <= win_d;
      nmi_ex_q <= nmi_ex_d;
      l1_ex_q <= l1_ex_d;
      l0_ex_q <= l0_ex_d;
    end
  end

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_RR_LOAD: assert property (
    rr_load |=> (pri_q == $past(win_q))
  ) else $error("pointer not loaded with acknowledged vector");

  AST_PROT_KEEP: assert property (
    (wr && idx == IDX_CTRL && unlk_q == 3'h0) |=> ($stable(cvt_q) && $stable(vector_placement_select_q))
  ) else $error("protected bits changed without unlock");

  AST_RR_FREE: assert property (
    (wr && idx == IDX_CTRL) |=> (rr_q == $past(pwdata[CTRL_RR]))
  ) else $error("round-robin bit did not take the write");

  AST_NMI_ENTER: assert property (
    (take && offer_q.lvl == LVL_NMI) |=> nmi_ex_q ##1 !offer_q.req
  ) else $error("non-maskable entry not recorded");

  AST_RETURN_FROM_INTERRUPT_RESTORE: assert property (
    (return_from_interrupt && nmi_ex_q && !take) |=> (!nmi_ex_q && $stable(l1_ex_q) && $stable(l0_ex_q))
  ) else $error("return did not restore previous level");

  AST_L1_KEPT: assert property (
    (l1_ex_q && nmi_ex_q && !return_from_interrupt) |=> l1_ex_q
  ) else $error("level 1 flag lost under preemption");

  AST_L0_KEPT: assert property (
    (l0_ex_q && (l1_ex_q || nmi_ex_q) && !return_from_interrupt) |=> l0_ex_q
  ) else $error("level 0 flag lost under preemption");

  AST_NO_NMI_PREEMPT: assert property (
    nmi_ex_q |-> !offer_q.req
  ) else $error("offer raised while non-maskable runs");

  AST_L1_OFF: assert property (
    (hvec_q == HVEC_NONE && $past(hvec_q) == HVEC_NONE) |-> !(offer_q.req && offer_q.lvl == LVL_1)
  ) else $error("level 1 offered while disabled");

  AST_CVT_SHARED: assert property (
    (offer_q.req && offer_q.lvl == LVL_0 && $past(cvt_q) && $past(state_q) != ST_OFFER)
      |-> (offer_q.vec == CVT_VEC_L0)
  ) else $error("compact table level 0 vector wrong");

  AST_STAT_RO: assert property (
    (wr && idx == IDX_STAT && !take && !return_from_interrupt)
      |=> ({nmi_ex_q, l1_ex_q, l0_ex_q} == $past({nmi_ex_q, l1_ex_q, l0_ex_q}))
  ) else $error("status changed by software write");

  AST_PLACE: assert property (
    (vector_placement_select_q && !boot_all) ##1 boot_all |-> vec_boot_start ##1 !vec_boot_start
  ) else $error("vector placement output wrong");

  AST_APB_ANSWER: assert property (
    setup |=> pready ##1 !pready
  ) else $error("bus answer not one access cycle");

  CV_NMI_OVER_L0: cover property (l0_ex_q && !l1_ex_q ##1 nmi_ex_q);
  CV_RR_LOAD: cover property (rr_load);
  CV_UNLOCKED_WRITE: cover property (wr && idx == IDX_CTRL && unlk_q != 3'h0);
  CV_L1_OVER_L0: cover property (l0_ex_q ##1 l1_ex_q && l0_ex_q);

endmodule // cipc_core_interrupt_unit

// [cipc_core_model.sv]
// Behavioural processor core that takes offers and returns from handlers
`timescale 1ns/1ps
module cipc_core_model import cipc_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Controller side
  input wire cipc_offer_s offer,
  output logic int_ack,
  output logic return_from_interrupt,
  // Bench control
  input wire logic [3:0] ack_wait,
  input wire logic ret_req,
  output cipc_offer_s taken
);
  logic [3:0] cnt;
  // A slow core lets the offer be re-evaluated before it is taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
      int_ack <= 1'b0;
      return_from_interrupt <= 1'b0;
      taken <= '0;
    end else begin
      return_from_interrupt <= ret_req;
      int_ack <= 1'b0;
      if (int_ack && offer.req) begin
        taken <= offer;
      end
      if (offer.req && !int_ack) begin
        if (cnt == ack_wait) begin
          int_ack <= 1'b1;
          cnt <= 4'h0;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end else begin
        cnt <= 4'h0;
      end
    end
  end
endmodule // cipc_core_model

// [cpu_interrupt_priority_controller_test.sv]
// Self-checking bench of the core interrupt unit
`timescale 1ns/1ps
module cpu_interrupt_priority_controller_test import cipc_pkg::*;;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [NVEC-1:0] irq_lines = '0;
  logic gie = 1'b0;
  logic instr_done = 1'b0;
  logic boot_all = 1'b0;
  logic int_ack;
  logic return_from_interrupt;
  logic vec_boot_start;
  logic ret_req = 1'b0;
  logic [3:0] ack_wait = 4'h0;
  cipc_offer_s offer;
  cipc_offer_s taken;
  logic err;
  logic [31:0] rd;
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;

  // 200 MHz clock
  always #2.5 pclk = ~pclk;

  cipc_core_interrupt_unit DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_lines(irq_lines), .gie(gie),
    .instr_done(instr_done), .int_ack(int_ack), .return_from_interrupt(return_from_interrupt), .boot_all(boot_all),
    .offer(offer), .vec_boot_start(vec_boot_start));

  cipc_core_model core (.pclk(pclk), .presetn(presetn), .offer(offer), .int_ack(int_ack),
    .return_from_interrupt(return_from_interrupt), .ack_wait(ack_wait), .ret_req(ret_req), .taken(taken));

  // ****************************************************
  // Shared tasks
  // ****************************************************
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [2:0] i, input logic [7:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {3'h0, i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout may end this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next setup never re-drives psel in this step
    @(posedge pclk);
  endtask

  task automatic rdchk(input logic [2:0] i, input logic [7:0] exp);
    apb(1'b0, i, 8'h00);
    chk("register", {24'h0, exp}, rd);
  endtask

  // Wait for the core to take an offer and judge it and the status
  task automatic serve(input logic [7:0] vec, input logic [1:0] lvl, input logic [7:0] st);
    int n;
    n = 0;
    // Non-maskable entries are served with global enable low on purpose
    gie <= (lvl != LVL_NMI);
    while (int_ack !== 1'b1 && n < 60) begin
      @(posedge pclk);
      n++;
    end
    @(negedge pclk);
    chk("taken", {21'h0, 1'b1, lvl, vec}, {21'h0, taken});
    @(posedge pclk);
    rdchk(IDX_STAT, st);
  endtask

  task automatic ret(input logic [7:0] st);
    // Enable drops so the core takes no maskable offer until the next serve; non-maskable ignores it
    gie <= 1'b0;
    ret_req <= 1'b1;
    @(posedge pclk);
    ret_req <= 1'b0;
    repeat (3) @(posedge pclk);
    rdchk(IDX_STAT, st);
  endtask

  // ****************************************************
  // Scenarios
  // ****************************************************
  task automatic t_regs();
    for (int i = 0; i < 5; i++) begin
      rdchk(i[2:0], 8'h00);
    end
    apb(1'b1, 3'h5, 8'hff);
    chk("unmapped error", 32'h1, {31'h0, err});
    apb(1'b1, IDX_STAT, 8'hff);
    rdchk(IDX_STAT, 8'h00);
  endtask

  task automatic t_protect();
    apb(1'b1, IDX_CTRL, 8'h61);
    rdchk(IDX_CTRL, 8'h01);
    apb(1'b1, IDX_UNLK, UNLOCK_KEY);
    apb(1'b1, IDX_CTRL, 8'h60);
    rdchk(IDX_CTRL, 8'h60);
    @(negedge pclk);
    chk("boot start", 32'h1, {31'h0, vec_boot_start});
    @(posedge pclk);
    boot_all <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("boot all", 32'h0, {31'h0, vec_boot_start});
    boot_all <= 1'b0;
    apb(1'b1, IDX_UNLK, UNLOCK_KEY);
    repeat (5) begin
      instr_done <= 1'b1;
      @(posedge pclk);
      instr_done <= 1'b0;
      @(posedge pclk);
    end
    apb(1'b1, IDX_CTRL, 8'h00);
    rdchk(IDX_CTRL, 8'h60);
  endtask

  task automatic t_nest();
    ack_wait <= 4'h3;
    irq_lines[5] <= 1'b1;
    serve(CVT_VEC_L0, LVL_0, 8'h01);
    irq_lines[5] <= 1'b0;
    ack_wait <= 4'h0;
    apb(1'b1, IDX_HVEC, 8'h07);
    irq_lines[7] <= 1'b1;
    serve(CVT_VEC_L1, LVL_1, 8'h03);
    irq_lines[7] <= 1'b0;
    irq_lines[1] <= 1'b1;
    serve(CVT_VEC_NMI, LVL_NMI, 8'h83);
    irq_lines[1] <= 1'b0;
    ret(8'h03);
    ret(8'h01);
    ret(8'h00);
    apb(1'b1, IDX_UNLK, UNLOCK_KEY);
    apb(1'b1, IDX_CTRL, 8'h00);
    apb(1'b1, IDX_HVEC, HVEC_NONE);
    irq_lines[7] <= 1'b1;
    serve(8'h07, LVL_0, 8'h01);
    irq_lines[7] <= 1'b0;
    ret(8'h00);
  endtask

  task automatic t_order();
    irq_lines <= 32'h0010_0208;
    serve(8'h03, LVL_0, 8'h01);
    ret(8'h00);
    serve(8'h03, LVL_0, 8'h01);
    ret(8'h00);
    apb(1'b1, IDX_PRI, 8'h03);
    serve(8'h09, LVL_0, 8'h01);
    ret(8'h00);
    apb(1'b1, IDX_PRI, 8'h14);
    serve(8'h03, LVL_0, 8'h01);
    ret(8'h00);
    apb(1'b1, IDX_CTRL, 8'h01);
    rdchk(IDX_CTRL, 8'h01);
    serve(8'h03, LVL_0, 8'h01);
    rdchk(IDX_PRI, 8'h03);
    ret(8'h00);
    serve(8'h09, LVL_0, 8'h01);
    ret(8'h00);
    serve(8'h14, LVL_0, 8'h01);
    rdchk(IDX_PRI, 8'h14);
    ret(8'h00);
    irq_lines <= '0;
  endtask

  task automatic test_done();
    if (fail_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Cut a hang short
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      test_done();
    end
  end

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_protect();
    t_nest();
    t_order();
    test_done();
  end
endmodule // cpu_interrupt_priority_controller_test
